// ### shared/i2crec_pkg.sv
// Constants and types shared by the serial-bus slave recovery logic
`default_nettype none

package i2crec_pkg;

    // Slave bus address, arbitrary neutral value
    localparam logic [6:0] SLAVE_ADDR = 7'h20;
    // Bits in a data byte, and the index of the last bit
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // Reset values of the register pair and pointer
    localparam logic [7:0] REG0_RST = 8'h00;
    localparam logic [7:0] REG1_RST = 8'h00;
    localparam logic PTR_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_WRITE = 3'b011,
        ST_ACK_WR = 3'b100,
        ST_READ = 3'b101,
        ST_RACK = 3'b110
    } i2crec_state_t;

endpackage : i2crec_pkg

`default_nettype wire

// ### design/i2crec_slave.sv
// Serial-bus slave state machine with STOP, stuck-bus and hard-reset recovery
//
// Notes on behaviour
// - A STOP sends the slave to idle with the data line released, waiting for a START.
// - The slave pulls the data line low only while sending data bits or an acknowledge.
// - A byte is eight data bits plus an acknowledge, so nine clocks always release the data line; from a read address ack idle takes one more.
// - After its transmission ends, further clocks leave the slave idle until a START.
// - The slave never drives the clock line and never stretches it.
// - A hard reset by supply or reset pin returns all registers and the FSM to defaults.
// - At power-up the internal reset holds until the port supply reaches its trip level.
// - While the reset pin is low everything is held at default; it runs once it is high.
// - A new power-on reset needs the supply to fall below trip and rise again.
`timescale 1ns/1ns
`default_nettype none

module i2crec_slave
    import i2crec_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 25 MHz
    input wire logic rstn_i, // Synchronous reset, active low
    input wire logic reset_pin_n_i, // Hard reset pin, active low, async
    input wire logic supply_ok_i, // Port supply above trip level, async
    input wire logic scl_i, // Serial clock pin level
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive level, always low
    output logic sda_oe_o, // Serial data pulled low when high
    output logic [15:0] pair_data_o // Register pair, reg1 high byte
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
    logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
    logic rpin_s1_ff, rpin_s2_ff;
    logic sup_s1_ff, sup_s2_ff;
    logic hard_rst;

    // Reset and supply syncs start asserted so the core stays in reset
    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
        begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
            rpin_s1_ff <= 1'b0;
            rpin_s2_ff <= 1'b0;
            sup_s1_ff <= 1'b0;
            sup_s2_ff <= 1'b0;
        end
        else
        begin
            scl_s1_ff <= scl_i;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_i;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
            rpin_s1_ff <= reset_pin_n_i;
            rpin_s2_ff <= rpin_s1_ff;
            sup_s1_ff <= supply_ok_i;
            sup_s2_ff <= sup_s1_ff;
        end
    end

    // Level-based supply reset: released only above trip, rearmed only by a dip
    assign hard_rst = !rstn_i || !rpin_s2_ff || !sup_s2_ff;

    // ****************************************
    // Bus condition detection
    // ****************************************
    logic scl_rise, scl_fall, start_det, stop_det;

    assign scl_rise = scl_s2_ff && !scl_s3_ff;
    assign scl_fall = !scl_s2_ff && scl_s3_ff;
    // Both clock samples high so a data edge near a clock edge is not misread
    assign start_det = scl_s2_ff && scl_s3_ff && sda_s3_ff && !sda_s2_ff;
    assign stop_det = scl_s2_ff && scl_s3_ff && !sda_s3_ff && sda_s2_ff;

    // ****************************************
    // Slave state machine
    // ****************************************
    i2crec_state_t st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic oe_ff, nxt_oe;
    logic ack_ff, nxt_ack;
    logic first_ff, nxt_first;
    logic ptr_ff, nxt_ptr;
    logic [7:0] reg0_ff, nxt_reg0;
    logic [7:0] reg1_ff, nxt_reg1;

    function automatic logic [7:0] sel_byte(input logic p, input logic [7:0] r0,
                                            input logic [7:0] r1);
        sel_byte = p ? r1 : r0;
    endfunction : sel_byte

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_oe = oe_ff;
        nxt_ack = ack_ff;
        nxt_first = first_ff;
        nxt_ptr = ptr_ff;
        nxt_reg0 = reg0_ff;
        nxt_reg1 = reg1_ff;
        if (stop_det)
        begin
            nxt_st = ST_IDLE;
            nxt_oe = 1'b0;
            nxt_cnt = 4'h0;
        end
        else if (start_det)
        begin
            nxt_st = ST_ADDR;
            nxt_oe = 1'b0;
            nxt_cnt = 4'h0;
            nxt_first = 1'b1;
        end
        else
        begin
            case (st_ff)
                ST_IDLE:
                begin
                    nxt_oe = 1'b0;
                end
                ST_ADDR, ST_WRITE:
                begin
                    if (scl_rise && cnt_ff < BYTE_BITS)
                    begin
                        nxt_sh = {sh_ff[6:0], sda_s2_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    else if (scl_fall && cnt_ff == BYTE_BITS)
                    begin
                        nxt_cnt = 4'h0;
                        if (st_ff == ST_ADDR)
                        begin
                            if (sh_ff[7:1] == SLAVE_ADDR)
                            begin
                                nxt_st = ST_ACK_ADDR;
                                nxt_oe = 1'b1;
                            end
                            else
                            begin
                                nxt_st = ST_IDLE;
                            end
                        end
                        else
                        begin
                            if (first_ff)
                            begin
                                nxt_ptr = sh_ff[0];
                                nxt_first = 1'b0;
                            end
                            else
                            begin
                                if (ptr_ff)
                                    nxt_reg1 = sh_ff;
                                else
                                    nxt_reg0 = sh_ff;
                                nxt_ptr = !ptr_ff;
                            end
                            nxt_st = ST_ACK_WR;
                            nxt_oe = 1'b1;
                        end
                    end
                end
                ST_ACK_ADDR:
                begin
                    if (scl_fall)
                    begin
                        if (sh_ff[0])
                        begin
                            nxt_sh = sel_byte(ptr_ff, reg0_ff, reg1_ff);
                            nxt_oe = !nxt_sh[7];
                            nxt_st = ST_READ;
                        end
                        else
                        begin
                            nxt_oe = 1'b0;
                            nxt_st = ST_WRITE;
                        end
                    end
                end
                ST_ACK_WR:
                begin
                    if (scl_fall)
                    begin
                        nxt_oe = 1'b0;
                        nxt_st = ST_WRITE;
                    end
                end
                ST_READ:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_ff == LAST_BIT)
                        begin
                            // Release for master acknowledge; frame ends at bit nine
                            nxt_cnt = 4'h0;
                            nxt_oe = 1'b0;
                            nxt_st = ST_RACK;
                        end
                        else
                        begin
                            nxt_cnt = cnt_ff + 4'h1;
                            nxt_sh = {sh_ff[6:0], 1'b0};
                            nxt_oe = !sh_ff[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        nxt_ack = !sda_s2_ff;
                    else if (scl_fall)
                    begin
                        if (ack_ff)
                        begin
                            nxt_ptr = !ptr_ff;
                            nxt_sh = sel_byte(!ptr_ff, reg0_ff, reg1_ff);
                            nxt_oe = !nxt_sh[7];
                            nxt_st = ST_READ;
                        end
                        else
                        begin
                            // Released line during recovery reads as no-ack
                            nxt_st = ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    nxt_st = ST_IDLE;
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (hard_rst)
        begin
            st_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            oe_ff <= 1'b0;
            ack_ff <= 1'b0;
            first_ff <= 1'b1;
            ptr_ff <= PTR_RST;
            reg0_ff <= REG0_RST;
            reg1_ff <= REG1_RST;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            oe_ff <= nxt_oe;
            ack_ff <= nxt_ack;
            first_ff <= nxt_first;
            ptr_ff <= nxt_ptr;
            reg0_ff <= nxt_reg0;
            reg1_ff <= nxt_reg1;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = oe_ff;
    assign pair_data_o = {reg1_ff, reg0_ff};

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (hard_rst);

    chk_stop_idle: assert property (stop_det |=> st_ff == ST_IDLE && !sda_oe_o)
        else $error("STOP did not return slave to idle");
    chk_sda_change: assert property ($changed(sda_oe_o) && !$past(start_det)
            && !$past(stop_det) |-> !scl_s2_ff)
        else $error("Data drive changed while clock high");
    chk_ack_drive: assert property (st_ff == ST_ACK_ADDR |-> sda_oe_o)
        else $error("Address acknowledge not driven");
    chk_frame_bound: assert property (cnt_ff <= BYTE_BITS)
        else $error("Bit counter beyond one byte");
    chk_nack_idle: assert property (st_ff == ST_RACK && scl_fall && !ack_ff && !stop_det
            && !start_det |=> st_ff == ST_IDLE ##1 !sda_oe_o)
        else $error("No-ack did not end transmission");
    chk_idle_quiet: assert property (st_ff == ST_IDLE && !start_det |=> st_ff == ST_IDLE
            && !sda_oe_o)
        else $error("Idle slave left idle without START");
    chk_start_sync: assert property (start_det && !stop_det |=> st_ff == ST_ADDR
            && cnt_ff == 4'h0)
        else $error("START did not resync bit counter");
    chk_reset_hold: assert property (disable iff (1'b0) hard_rst |=> st_ff == ST_IDLE
            && !sda_oe_o && pair_data_o == {REG1_RST, REG0_RST})
        else $error("Hard reset did not restore defaults");
    chk_pin_reset: assert property (disable iff (!rstn_i) $fell(rpin_s2_ff)
            |=> st_ff == ST_IDLE [*2])
        else $error("Reset pin did not hold defaults");
    chk_supply_hold: assert property (disable iff (!rstn_i) !sup_s2_ff
            |=> !sda_oe_o && st_ff == ST_IDLE)
        else $error("Low supply did not hold reset");

endmodule : i2crec_slave

`default_nettype wire

// ### dv/i2crec_master.sv
// Bus master model that drives the serial clock and data lines
`timescale 1ns/1ns
`default_nettype none

module i2crec_master (
    input wire logic sys_clk_i, // System clock
    input wire logic sda_i, // Data wire level
    output logic scl_o, // Clock line, idle high
    output logic sda_low_o // High pulls data low
);
    // ********************
    // Line sequencing
    // ********************
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // All moves land just after a system clock edge
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tk

    // Works from idle or mid-byte, so a repeated start can cut a byte short
    task automatic start();
        if (!scl_o)
        begin
            tk(3);
            sda_low_o = 1'b0;
            tk(3);
            scl_o = 1'b1;
            tk(4);
        end
        sda_low_o = 1'b1;
        tk(4);
        scl_o = 1'b0;
    endtask : start

    task automatic stop();
        tk(3);
        sda_low_o = 1'b1;
        tk(3);
        scl_o = 1'b1;
        tk(4);
        sda_low_o = 1'b0;
        tk(4);
    endtask : stop

    // Eight-cycle bit: data moves mid-low, three cycles clear of both edges
    task automatic bit_x(input logic b, output logic r);
        tk(3);
        sda_low_o = !b;
        tk(3);
        scl_o = 1'b1;
        tk(1);
        r = sda_i;
        tk(1);
        scl_o = 1'b0;
    endtask : bit_x

    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_x(tx[i], rx[i]);
        bit_x(mack, ack);
    endtask : xfer

    // Blind clocks with data released, to free a stuck line
    task automatic nine();
        logic r;
        repeat (9) bit_x(1'b1, r);
    endtask : nine
endmodule : i2crec_master

`default_nettype wire

// ### dv/i2crec_slave_tb_top.sv
// Self-checking bench for the slave recovery logic
`timescale 1ns/1ns
`default_nettype none

module i2crec_slave_tb_top;
    import i2crec_pkg::*;
    localparam logic [7:0] adr_wr = {SLAVE_ADDR, 1'b0};
    localparam logic [7:0] adr_rd = {SLAVE_ADDR, 1'b1};
    logic sys_clk_i;
    logic rstn_i;
    logic reset_pin_n_i;
    logic supply_ok_i;
    logic scl, m_low, sda_o, sda_oe_o, ack;
    logic [7:0] rx;
    logic [15:0] pair_data_o;
    logic [31:0] seed = 32'h70950976;
    logic [7:0] mreg [2];
    int ptr;
    int failures = 0;
    int comparisons = 0;
    wire logic sda_w;

    always #20 sys_clk_i = !sys_clk_i;
    // Pull-up wins unless someone pulls low
    assign sda_w = !(sda_oe_o && !sda_o) && !m_low;

    i2crec_slave i2crec_slave_inst (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .reset_pin_n_i(reset_pin_n_i),
        .supply_ok_i(supply_ok_i),
        .scl_i(scl),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .pair_data_o(pair_data_o)
    );

    i2crec_master i2crec_master_inst (
        .sys_clk_i(sys_clk_i),
        .sda_i(sda_w),
        .scl_o(scl),
        .sda_low_o(m_low)
    );

    // ********************
    // Checks and bus tasks
    // ********************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic wr(input logic [7:0] cmd, input int n);
        i2crec_master_inst.start();
        i2crec_master_inst.xfer(adr_wr, 1'b1, rx, ack);
        chk({15'h0, ack}, 16'h0);
        i2crec_master_inst.xfer(cmd, 1'b1, rx, ack);
        chk({15'h0, ack}, 16'h0);
        ptr = cmd[0];
        repeat (n)
        begin
            seed = lfsr(seed);
            i2crec_master_inst.xfer(seed[7:0], 1'b1, rx, ack);
            mreg[ptr] = seed[7:0];
            ptr ^= 1;
            chk({15'h0, ack}, 16'h0);
            chk(pair_data_o, {mreg[1], mreg[0]});
        end
        i2crec_master_inst.stop();
        chk({15'h0, sda_oe_o}, 16'h0);
    endtask : wr

    // Pointer moves on only after a byte the master acknowledged
    task automatic rd(input int n);
        i2crec_master_inst.start();
        i2crec_master_inst.xfer(adr_rd, 1'b1, rx, ack);
        chk({15'h0, ack}, 16'h0);
        for (int i = 1; i <= n; i++)
        begin
            i2crec_master_inst.xfer(8'hFF, i == n, rx, ack);
            chk({8'h0, rx}, {8'h0, mreg[ptr]});
            if (i < n)
                ptr ^= 1;
        end
        i2crec_master_inst.stop();
        chk({15'h0, sda_oe_o}, 16'h0);
    endtask : rd

    // Sel 0 pin, 1 supply, 2 sync reset; bus must be deaf while held
    task automatic hold(input int sel);
        {reset_pin_n_i, supply_ok_i, rstn_i} = ~(3'b100 >> sel);
        i2crec_master_inst.tk(4);
        i2crec_master_inst.start();
        i2crec_master_inst.xfer(adr_wr, 1'b1, rx, ack);
        chk({15'h0, ack}, 16'h1);
        i2crec_master_inst.stop();
        chk(pair_data_o, 16'h0);
        {reset_pin_n_i, supply_ok_i, rstn_i} = 3'b111;
        i2crec_master_inst.tk(8);
        mreg = '{8'h00, 8'h00};
        ptr = 0;
    endtask : hold

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        close_out();
    end

    initial
    begin
        sys_clk_i = 1'b0;
        rstn_i = 1'b0;
        reset_pin_n_i = 1'b1;
        supply_ok_i = 1'b0;
        mreg = '{8'h00, 8'h00};
        ptr = 0;
        i2crec_master_inst.tk(8);
        hold(1);
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(seed[7:0], int'(seed[9:8]) + 1);
            rd(int'(seed[11:10]) + 1);
        end
        seed = lfsr(seed);
        i2crec_master_inst.start();
        rx = {seed[6:0] == SLAVE_ADDR ? ~SLAVE_ADDR : seed[6:0], seed[7]};
        i2crec_master_inst.xfer(rx, 1'b1, rx, ack);
        chk({15'h0, ack}, 16'h1);
        i2crec_master_inst.nine();
        chk({15'h0, sda_oe_o}, 16'h0);
        i2crec_master_inst.stop();
        // Abandon a read at its address ack, slave left pulling low
        i2crec_master_inst.start();
        for (int i = 7; i >= 0; i--)
            i2crec_master_inst.bit_x(adr_rd[i], ack);
        i2crec_master_inst.tk(5);
        chk({15'h0, sda_oe_o}, 16'h1);
        i2crec_master_inst.nine();
        i2crec_master_inst.tk(5);
        chk({15'h0, sda_oe_o}, 16'h0);
        i2crec_master_inst.nine();
        i2crec_master_inst.tk(5);
        chk({15'h0, sda_oe_o}, 16'h0);
        chk(pair_data_o, {mreg[1], mreg[0]});
        i2crec_master_inst.stop();
        // Stop, then a repeated start, each three bits into a byte
        i2crec_master_inst.start();
        i2crec_master_inst.xfer(adr_wr, 1'b1, rx, ack);
        repeat (3) i2crec_master_inst.bit_x(1'b0, ack);
        i2crec_master_inst.stop();
        chk({15'h0, sda_oe_o}, 16'h0);
        i2crec_master_inst.start();
        i2crec_master_inst.xfer(adr_wr, 1'b1, rx, ack);
        repeat (3) i2crec_master_inst.bit_x(1'b1, ack);
        wr(8'h01, 2);
        for (int s = 0; s < 3; s++)
        begin
            wr(8'h00, 2);
            hold(s);
        end
        close_out();
    end
endmodule : i2crec_slave_tb_top

`default_nettype wire
